// ==== rtl/tpo_pkg.sv ====
package tpo_pkg;

  // Register offsets (byte addresses on APB)
  localparam int            ADDR_W        = 8;
  localparam logic [7:0]    OFS_CH5_CLK   = 8'h00;
  localparam logic [7:0]    OFS_MODE_BASE = 8'h04;
  localparam logic [7:0]    OFS_OUT_EN    = 8'h18;
  localparam logic [7:0]    OFS_OCR1      = 8'h1C;
  localparam logic [7:0]    OFS_OCR2      = 8'h20;
  localparam logic [7:0]    OFS_LVL_BUF   = 8'h24;
  localparam logic [7:0]    OFS_DEAD      = 8'h28;
  localparam logic [7:0]    OFS_STATUS    = 8'h2C;
  localparam int            NUM_MODE      = 5;

  // Write masks and field positions
  localparam logic [7:0]    CH5_WMASK     = 8'h03;
  localparam logic [7:0]    MODE0_WMASK   = 8'h7F;
  localparam logic [7:0]    MODEN_WMASK   = 8'h3F;
  localparam logic [7:0]    OCR1_WMASK    = 8'h4F;
  localparam logic [7:0]    LVL_MASK      = 8'h3F;
  localparam int            BIT_BFE       = 6;
  localparam int            BIT_PERIOD_TOGGLE_ENABLE      = 6;
  localparam int            BIT_LOCK      = 3;
  localparam int            BIT_LEVEL_SELECT_SOURCE      = 2;
  localparam int            BIT_POS_PHASE_LEVEL      = 0;
  localparam int            BIT_BF_HI     = 7;
  localparam int            BIT_BF_LO     = 6;
  localparam int            BIT_OLS4D     = 5;
  localparam int            BIT_OLS3B     = 0;
  localparam logic [7:0]    RESET_BYTE    = 8'h00;

  // Prescale codes and divider terminal counts
  localparam logic [1:0]    PSC_DIV1      = 2'h0;
  localparam logic [1:0]    PSC_DIV1B     = 2'h1;
  localparam logic [1:0]    PSC_DIV16     = 2'h2;
  localparam logic [1:0]    PSC_DIV64     = 2'h3;
  localparam logic [5:0]    DIV16_LAST    = 6'h0F;
  localparam logic [5:0]    DIV64_LAST    = 6'h3F;

  // Operating mode field codes
  localparam logic [3:0]    MD_PWM1       = 4'h2;
  localparam logic [3:0]    MD_PWM2       = 4'h3;
  localparam logic [3:0]    MD_RSYNC      = 4'h8;
  localparam logic [3:0]    MD_COMP_MIN   = 4'hD;

  // Buffer-transfer codes
  localparam logic [1:0]    XFER_NONE     = 2'h0;
  localparam logic [1:0]    XFER_CREST    = 2'h1;
  localparam logic [1:0]    XFER_TROUGH   = 2'h2;
  localparam logic [1:0]    XFER_BOTH     = 2'h3;

  // Compare output pin indices
  localparam int            PIN_0A = 0;
  localparam int            PIN_0B = 1;
  localparam int            PIN_0C = 2;
  localparam int            PIN_0D = 3;
  localparam int            PIN_1A = 4;
  localparam int            PIN_1B = 5;
  localparam int            PIN_2A = 6;
  localparam int            PIN_2B = 7;
  localparam int            PIN_3A = 8;
  localparam int            PIN_3C = 9;
  localparam int            NUM_PIN = 10;

  typedef struct packed {
    logic       ch4_crest;
    logic       ch4_trough;
    logic       ch34_clear;
    logic       count_start;
    logic       ch4_down;
    logic       ch4_cmp_d;
    logic       ch3b_wave;
    logic [5:0] ch0_match;
    logic       ch0_ovf;
    logic [2:0] ch5_match;
  } tpo_evt_t;

  typedef struct packed {
    logic [NUM_PIN-1:0] pin;
    logic               ch3_pin_b;
    logic               ch4_pin_d;
    logic               sync_toggle;
  } tpo_pins_t;

endpackage

// ==== rtl/tpo_prescaler.sv ====
module tpo_prescaler
  import tpo_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  // Control
  input  wire logic [1:0] i_sel,
  // Count enable
  output logic            o_tick
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } tpo_psc_state_t;

  tpo_psc_state_t q;
  tpo_psc_state_t d;

  always_comb
  begin
    d = q;
    d.cnt = q.cnt + 6'h01;
    case (i_sel)
      PSC_DIV16: d.tick = (q.cnt[3:0] == DIV16_LAST[3:0]); // R1
      PSC_DIV64: d.tick = (q.cnt == DIV64_LAST); // R1
      default:   d.tick = 1'b1; // R1
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      q <= '0;
    else
      q <= d;
  end

  assign o_tick = q.tick;

  undiv_tick_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R1
    (i_sel == PSC_DIV1) ##1 (i_sel == PSC_DIV1) |-> o_tick)
    else $error("undivided count clock missed a tick");

  div16_gap_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R1
    o_tick && (i_sel == PSC_DIV16) && $past(i_sel) == PSC_DIV16
    ##1 (i_sel == PSC_DIV16) [*8] |-> !o_tick)
    else $error("divide by 16 ticks too often");

endmodule

// ==== rtl/tpo_dead_time.sv ====
module tpo_dead_time
  import tpo_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  // Count start and programmed delay
  input  wire logic       i_start,
  input  wire logic [7:0] i_dead,
  // Dead time elapsed
  output logic            o_elapsed
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       run;
    logic       done;
  } tpo_dt_state_t;

  tpo_dt_state_t q;
  tpo_dt_state_t d;

  always_comb
  begin
    d = q;
    if (i_start)
    begin
      d.cnt  = '0;
      d.run  = 1'b1;
      d.done = 1'b0;
    end
    else if (q.run)
    begin
      if (q.cnt >= i_dead)
      begin
        d.run  = 1'b0;
        d.done = 1'b1; // R18
      end
      else
        d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      q <= '0;
    else
      q <= d;
  end

  assign o_elapsed = q.done;

  start_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R18
    i_start |=> !o_elapsed)
    else $error("reverse phase left initial level at count start");

  elapse_late_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R18
    i_start && (i_dead == 8'h02) ##1 !i_start [*3] |-> !o_elapsed)
    else $error("dead time elapsed too early");

endmodule

// ==== rtl/tpo_output_ctrl.sv ====
// Behaviour
// R1: Channel 5 prescale code 00 undivided, 10 divide by 16, 11 by 64.
// R2: Channel 5 clock register bits 7..2 read zero, writes ignored.
// R3: Five 8-bit read/write mode registers, channels 0..4, reset to zero.
// R4: Software changes a mode register only while that counter is stopped.
// R5: Channel 0 mode bit 6 makes F buffer E; F match still raised.
// R6: Channels 1..4 mode bit 6 reserved, reads zero.
// R7: Enable bit 0 gates channel 3 B pin; cleared holds inactive level.
// R8: Inactive level from output control; outside PWM sync modes it is low.
// R9: Output control one bit 6 enables PWM-period toggle output.
// R10: Output control one bit 3 is set once, cleared only by reset.
// R11: Output control one bits 7, 5, 4 reserved, read zero.
// R12: Channel 3 B level select acts only when source bit is set.
// R13: Transfer code 00 never copies the level buffer.
// R14: Code 01 copies at crest (complementary) or counter clear (reset-sync).
// R15: Code 10 copies at trough in complementary; none in reset-sync.
// R16: Code 11 copies at crest and trough in complementary only.
// R17: Output control two bit 5 inverts channel 4 D levels.
// R18: Reverse phase holds initial level until dead time elapses.
// R19: PWM mode 1 drives pins from A, C of channels 0, 3 and A of 1, 2.
// R20: PWM mode 2 drives every channel 0..2 pin; channel 3 cannot use it.
// R21: Channel 0 raises seven sources: A..D, E, F and overflow.
// R22: Channel 5 raises three sources U, V, W; no overflow.
//
// Our own choices: the APB register port and the address map.
module tpo_output_ctrl
  import tpo_pkg::*;
(
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  // APB slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [ADDR_W-1:0]  i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic [31:0]             o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  // Timer core events and waveforms
  input  wire tpo_evt_t           i_evt,
  input  wire logic [NUM_PIN-1:0] i_wave,
  // Output pins
  output tpo_pins_t               o_pins,
  // Channel 5 count enable
  output logic                    o_ch5_tick,
  // Interrupt sources and buffer transfer
  output logic [6:0]              o_ch0_irq_src,
  output logic [2:0]              o_ch5_irq_src,
  output logic                    o_ef_buffer_xfer
);

  typedef struct packed {
    logic [1:0]               ch5_psc;
    logic [NUM_MODE-1:0][7:0] mode;
    logic                     ch3b_output_enable;
    logic [7:0]               ocr1;
    logic [7:0]               ocr2;
    logic [7:0]               lvl_buf;
    logic [7:0]               dead;
    logic [31:0]              rdata;
    logic                     toggle;
    logic [6:0]               ch0_irq;
    logic [2:0]               ch5_irq;
    logic                     ef_xfer;
    tpo_pins_t                pins;
  } tpo_main_state_t;

  tpo_main_state_t q;
  tpo_main_state_t d;

  logic setup_rd;
  logic access_wr;
  logic xfer;
  logic ch3_comp;
  logic ch3_rsync;
  logic dt_elapsed;
  logic ch3b_inact;

  function automatic logic is_comp(input logic [7:0] m);
    is_comp = (m[3:0] >= MD_COMP_MIN);
  endfunction

  function automatic logic is_rsync(input logic [7:0] m);
    is_rsync = (m[3:0] == MD_RSYNC);
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= OFS_STATUS);
  endfunction

  // Pin enable for one compare register, per mode of its channel
  function automatic logic pin_on(input logic [7:0] m, input int idx);
    logic p1;
    logic p2;
    p1 = (m[3:0] == MD_PWM1);
    p2 = (m[3:0] == MD_PWM2);
    case (idx)
      PIN_0A, PIN_0C, PIN_1A, PIN_2A: pin_on = p1 || p2; // R19 R20
      PIN_0B, PIN_0D, PIN_1B, PIN_2B: pin_on = p2; // R20
      PIN_3A, PIN_3C:                 pin_on = p1; // R19 R20
      default:                        pin_on = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] mode_of(input int idx);
    case (idx)
      PIN_0A, PIN_0B, PIN_0C, PIN_0D: mode_of = 8'h00;
      PIN_1A, PIN_1B:                 mode_of = 8'h01;
      PIN_2A, PIN_2B:                 mode_of = 8'h02;
      default:                        mode_of = 8'h03;
    endcase
  endfunction

  tpo_prescaler u_prescaler (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_sel     (q.ch5_psc),
    .o_tick    (o_ch5_tick)
  );

  tpo_dead_time u_dead_time (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_start   (i_evt.count_start),
    .i_dead    (q.dead),
    .o_elapsed (dt_elapsed)
  );

  assign setup_rd  = i_psel && !i_penable && !i_pwrite;
  assign access_wr = i_psel && i_penable && i_pwrite && addr_ok(i_paddr);
  assign ch3_comp  = is_comp(q.mode[3]);
  assign ch3_rsync = is_rsync(q.mode[3]);

  // Level buffer transfer condition
  always_comb
  begin
    xfer = 1'b0;
    if (ch3_comp)
    begin
      case ({q.ocr2[BIT_BF_HI], q.ocr2[BIT_BF_LO]})
        XFER_CREST:  xfer = i_evt.ch4_crest; // R14
        XFER_TROUGH: xfer = i_evt.ch4_trough; // R15
        XFER_BOTH:   xfer = i_evt.ch4_crest || i_evt.ch4_trough; // R16
        default:     xfer = 1'b0; // R13
      endcase
    end
    else if (ch3_rsync)
      xfer = ({q.ocr2[BIT_BF_HI], q.ocr2[BIT_BF_LO]} == XFER_CREST)
             && i_evt.ch34_clear; // R14 R15 R16
  end

  // Channel 3 B inactive level
  always_comb
  begin
    if (ch3_comp || ch3_rsync)
      ch3b_inact = q.ocr1[BIT_LEVEL_SELECT_SOURCE] ? q.ocr2[BIT_OLS3B] // R12
                                    : q.ocr1[BIT_POS_PHASE_LEVEL];
    else
      ch3b_inact = 1'b0; // R8
  end

  always_comb
  begin
    d = q;
    d.rdata = q.rdata;
    if (setup_rd)
    begin
      d.rdata = '0;
      if (i_paddr == OFS_CH5_CLK)
        d.rdata[1:0] = q.ch5_psc; // R2
      else if (i_paddr == OFS_OUT_EN)
        d.rdata[0] = q.ch3b_output_enable;
      else if (i_paddr == OFS_OCR1)
        d.rdata[7:0] = q.ocr1; // R11
      else if (i_paddr == OFS_OCR2)
        d.rdata[7:0] = q.ocr2;
      else if (i_paddr == OFS_LVL_BUF)
        d.rdata[7:0] = q.lvl_buf;
      else if (i_paddr == OFS_DEAD)
        d.rdata[7:0] = q.dead;
      else if (i_paddr == OFS_STATUS)
        d.rdata[1:0] = {dt_elapsed, q.toggle};
      for (int i = 0; i < NUM_MODE; i++)
        if (i_paddr == OFS_MODE_BASE + 8'(i * 4))
          d.rdata[7:0] = q.mode[i]; // R3
    end

    if (access_wr)
    begin
      if (i_paddr == OFS_CH5_CLK)
        d.ch5_psc = i_pwdata[1:0] & CH5_WMASK[1:0]; // R2
      else if (i_paddr == OFS_OUT_EN)
        d.ch3b_output_enable = i_pwdata[0]; // R7
      else if (i_paddr == OFS_OCR1)
        d.ocr1 = (i_pwdata[7:0] & OCR1_WMASK)
                 | (q.ocr1 & (8'h01 << BIT_LOCK)); // R10 R11
      else if (i_paddr == OFS_OCR2)
        d.ocr2 = i_pwdata[7:0];
      else if (i_paddr == OFS_LVL_BUF)
        d.lvl_buf = i_pwdata[7:0] & LVL_MASK;
      else if (i_paddr == OFS_DEAD)
        d.dead = i_pwdata[7:0];
      for (int i = 0; i < NUM_MODE; i++)
        if (i_paddr == OFS_MODE_BASE + 8'(i * 4))
          d.mode[i] = i_pwdata[7:0]
                      & ((i == 0) ? MODE0_WMASK : MODEN_WMASK); // R3 R5 R6
    end

    // Hardware transfer wins the level bits over a same-cycle write
    if (xfer)
      d.ocr2 = (d.ocr2 & ~LVL_MASK) | (q.lvl_buf & LVL_MASK); // R14 R15 R16

    // Toggle at each PWM period boundary
    if (q.ocr1[BIT_PERIOD_TOGGLE_ENABLE] && ((ch3_comp && i_evt.ch4_crest)
        || (ch3_rsync && i_evt.ch34_clear)))
      d.toggle = !q.toggle; // R9
    else if (!q.ocr1[BIT_PERIOD_TOGGLE_ENABLE])
      d.toggle = 1'b0; // R9

    d.ch0_irq = {i_evt.ch0_ovf, i_evt.ch0_match}; // R21
    d.ch5_irq = i_evt.ch5_match; // R22
    d.ef_xfer = q.mode[0][BIT_BFE] && i_evt.ch0_match[4]; // R5

    for (int p = 0; p < NUM_PIN; p++)
      d.pins.pin[p] = pin_on(q.mode[mode_of(p)], p) && i_wave[p]; // R19 R20

    d.pins.ch3_pin_b = q.ch3b_output_enable ? i_evt.ch3b_wave : ch3b_inact; // R7 R8
    d.pins.sync_toggle = q.toggle;

    // Channel 4 D: compare output follows count direction
    if (i_evt.count_start)
      d.pins.ch4_pin_d = !q.ocr2[BIT_OLS4D]; // R17
    else if (!dt_elapsed)
      d.pins.ch4_pin_d = !q.ocr2[BIT_OLS4D]; // R18
    else if (i_evt.ch4_cmp_d)
      d.pins.ch4_pin_d = i_evt.ch4_down ? q.ocr2[BIT_OLS4D]
                                        : !q.ocr2[BIT_OLS4D]; // R17
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      q              <= '0;
      q.ocr1         <= RESET_BYTE;
      q.ocr2         <= RESET_BYTE;
      q.pins.ch4_pin_d <= 1'b1;
    end
    else
      q <= d;
  end

  assign o_prdata         = q.rdata;
  assign o_pready         = 1'b1;
  assign o_pslverr        = i_psel && i_penable && !addr_ok(i_paddr);
  assign o_pins           = q.pins;
  assign o_ch0_irq_src    = q.ch0_irq;
  assign o_ch5_irq_src    = q.ch5_irq;
  assign o_ef_buffer_xfer = q.ef_xfer;

  ch5_resv_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R2
    setup_rd && i_paddr == OFS_CH5_CLK |=> o_prdata[31:2] == '0)
    else $error("channel 5 reserved bits read nonzero");

  mode_resv_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R6
    setup_rd && i_paddr == OFS_MODE_BASE + 8'h04 |=> o_prdata[7:6] == 2'h0)
    else $error("channel 1 mode reserved bits read nonzero");

  lock_sticky_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R10
    q.ocr1[BIT_LOCK] |=> q.ocr1[BIT_LOCK])
    else $error("write-once lock bit cleared");

  ocr1_resv_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R11
    access_wr && i_paddr == OFS_OCR1 |=> (q.ocr1 & 8'hB0) == 8'h00)
    else $error("output control one reserved bits set");

  no_xfer_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R13
    q.ocr2[7:6] == XFER_NONE && !access_wr |=> $stable(q.ocr2))
    else $error("level buffer copied with transfer disabled");

  crest_copy_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R14
    ch3_comp && q.ocr2[7:6] == XFER_CREST && i_evt.ch4_crest
    |=> q.ocr2[5:0] == $past(q.lvl_buf[5:0]))
    else $error("crest transfer did not copy level buffer");

  rsync_trough_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R15
    ch3_rsync && q.ocr2[7:6] == XFER_TROUGH |-> !xfer)
    else $error("prohibited code transferred in reset-sync mode");

  pin_disable_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R7
    !q.ch3b_output_enable && !ch3_comp && !ch3_rsync ##1 !q.ch3b_output_enable |-> !o_pins.ch3_pin_b)
    else $error("disabled channel 3 B pin not low");

  ch3_mode2_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R20
    q.mode[3][3:0] == MD_PWM2 |=> !o_pins.pin[PIN_3A] && !o_pins.pin[PIN_3C])
    else $error("channel 3 pin driven in mode 2");

  mode1_b_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R19
    q.mode[0][3:0] == MD_PWM1 |=> !o_pins.pin[PIN_0B] && !o_pins.pin[PIN_0D])
    else $error("channel 0 B or D pin driven in mode 1");

  ef_buffer_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R5
    q.mode[0][BIT_BFE] && i_evt.ch0_match[5]
    |=> o_ch0_irq_src[5])
    else $error("F compare match lost in buffer mode");

  dead_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R18
    !dt_elapsed && !i_evt.count_start
    |=> o_pins.ch4_pin_d == !$past(q.ocr2[BIT_OLS4D]))
    else $error("reverse phase left initial level in dead time");

endmodule

// ==== dv/tpo_load_model.sv ====
module tpo_load_model
  import tpo_pkg::*;
(
  // Clock and observed pins
  input  wire logic      i_ref_clk,
  input  wire tpo_pins_t i_pins,
  // What the load sees
  output int             o_flips,
  output logic           o_ch3b_level
);
  timeunit 1ns;
  timeprecision 1ns;

  int   count_q = 0;
  logic prev_q  = 1'h0;

  // Counts every edge of the period toggle line
  always @(posedge i_ref_clk)
  begin
    if (i_pins.sync_toggle !== prev_q)
      count_q <= count_q + 1;
    prev_q <= i_pins.sync_toggle;
  end

  assign o_flips = count_q;

  // Load on the ch3 B pin follows the driven level
  assign o_ch3b_level = i_pins.ch3_pin_b;
endmodule

// ==== dv/test_timer_pwm_output_control.sv ====
module test_timer_pwm_output_control
  import tpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] REGS [9] = '{OFS_CH5_CLK, 8'h04, 8'h08, 8'h0C,
    8'h10, 8'h14, OFS_OUT_EN, OFS_OCR1, OFS_OCR2};
  localparam int         TICKS [4] = '{128, 128, 8, 2};

  logic               clk, rst, psel, pen, pwr, down, w3b, err, hit;
  logic               pready, pslverr, tick, efx, lvl3b;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [NUM_PIN-1:0] wave;
  logic [6:0]         irq0;
  logic [5:0]         b;
  logic [2:0]         irq5;
  logic [7:0]         mdl [int];
  tpo_evt_t           evt, evt_in, e;
  tpo_pins_t          pins;
  int                 bad_count, num_checks, seed, cyc, flips, n;

  always_comb
  begin
    evt_in = evt;
    evt_in.ch4_down = down;
    evt_in.ch3b_wave = w3b;
  end

  tpo_output_ctrl u_dut (
    .i_ref_clk (clk),    .i_reset       (rst),
    .i_psel    (psel),   .i_penable     (pen),
    .i_pwrite  (pwr),    .i_paddr       (paddr),
    .i_pwdata  (pwdata), .o_prdata      (prdata),
    .o_pready  (pready), .o_pslverr     (pslverr),
    .i_evt     (evt_in), .i_wave        (wave),
    .o_pins    (pins),   .o_ch5_tick    (tick),
    .o_ch0_irq_src (irq0), .o_ch5_irq_src (irq5),
    .o_ef_buffer_xfer (efx)
  );

  tpo_load_model u_load (
    .i_ref_clk (clk), .i_pins (pins), .o_flips (flips), .o_ch3b_level (lvl3b)
  );

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge clk);
      cyc++;
      if (cyc >= 20000)
      begin
        bad_count++;
        wrap_up();
      end
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Writable bits of each register from channel 5 clock to output control two
  function automatic logic [7:0] wmask(input logic [7:0] a);
    if (a == OFS_CH5_CLK) return 8'h03;
    if (a == OFS_MODE_BASE) return 8'h7F;
    if (a > OFS_MODE_BASE && a < OFS_OUT_EN) return 8'h3F;
    if (a == OFS_OUT_EN) return 8'h01;
    if (a == OFS_OCR1) return 8'h4F;
    return 8'hFF;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    // Lock bit survives any later write
    if (w && err !== 1'h1)
      mdl[a] = (d[7:0] & wmask(a)) |
               (a == OFS_OCR1 ? mdl[a] & 8'h08 : 8'h00);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a);
    apb(1'h0, a, 32'h0);
    check(what, rd, {24'h0, mdl[a]});
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input tpo_evt_t p);
    @(posedge clk);
    evt <= p;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask

  task automatic ch3b(input logic [3:0] md, input logic oe,
                      input logic [7:0] c1, input logic [7:0] c2,
                      input logic w, input logic exp);
    apb(1'h1, OFS_MODE_BASE + 8'h0C, {28'h0, md});
    apb(1'h1, OFS_OUT_EN, {31'h0, oe});
    apb(1'h1, OFS_OCR1, {24'h0, c1});
    apb(1'h1, OFS_OCR2, {24'h0, c2});
    @(posedge clk);
    w3b <= w;
    settle(2);
    check("ch3 B level", {31'h0, lvl3b}, {31'h0, exp});
  endtask

  initial
  begin
    seed = 53201;
    rst = 1'h1;
    {psel, pen, pwr, down, w3b} = '0;
    paddr = '0;
    pwdata = '0;
    evt = '0;
    wave = '0;
    bad_count = 0;
    num_checks = 0;
    foreach (REGS[i]) mdl[REGS[i]] = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    foreach (REGS[i])
    begin
      rdchk("reset value", REGS[i]);
      apb(1'h1, REGS[i], 32'hFF);
      rdchk("masked readback", REGS[i]);
    end
    apb(1'h1, OFS_OCR1, 32'h0);
    rdchk("lock bit", OFS_OCR1);
    apb(1'h1, 8'h05, 32'hFF);
    check("unaligned error", {31'h0, err}, 32'h1);
    apb(1'h0, 8'h30, 32'h0);
    check("unmapped read", rd, 32'h0);
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    foreach (REGS[i]) mdl[REGS[i]] = 8'h00;
    rdchk("lock after reset", OFS_OCR1);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'h1, OFS_CH5_CLK, c);
      settle(4);
      n = 0;
      repeat (128)
      begin
        @(posedge clk);
        #1;
        n += (tick === 1'h1);
      end
      check("prescale ticks", n, TICKS[c]);
    end
    // Counters stay stopped while modes change
    for (int p = 0; p < 2; p++)
    begin
      for (int c = 0; c < 4; c++)
        apb(1'h1, OFS_MODE_BASE + 8'(4 * c), p ? MD_PWM2 : MD_PWM1);
      repeat (3)
      begin
        @(posedge clk);
        wave <= NUM_PIN'($random(seed));
        settle(2);
        check("pin map", pins.pin, wave & (p ? 10'h0FF : 10'h355));
      end
    end
    ch3b(MD_PWM1, 1'h0, 8'h01, 8'h00, 1'h1, 1'h0);
    ch3b(MD_RSYNC, 1'h0, 8'h01, 8'h00, 1'h0, 1'h1);
    ch3b(MD_RSYNC, 1'h0, 8'h05, 8'h00, 1'h0, 1'h0);
    ch3b(MD_RSYNC, 1'h0, 8'h05, 8'h01, 1'h0, 1'h1);
    ch3b(MD_PWM1, 1'h1, 8'h00, 8'h00, 1'h1, 1'h1);
    ch3b(MD_PWM1, 1'h1, 8'h00, 8'h00, 1'h0, 1'h0);
    for (int m = 0; m < 2; m++)
    begin
      apb(1'h1, OFS_MODE_BASE + 8'h0C, m ? MD_RSYNC : MD_COMP_MIN);
      for (int c = 0; c < 4; c++)
        for (int v = 0; v < 3; v++)
        begin
          b = 6'($random(seed)) | 6'h21;
          apb(1'h1, OFS_LVL_BUF, {26'h0, b});
          apb(1'h1, OFS_OCR2, {24'h0, c[1:0], 6'h00});
          e = '0;
          e.ch4_crest = (v == 0);
          e.ch4_trough = (v == 1);
          e.ch34_clear = (v == 2);
          pulse(e);
          hit = m ? (v == 2 && c == 1) : (v == 0 && c[0]) || (v == 1 && c[1]);
          apb(1'h0, OFS_OCR2, 32'h0);
          check("level transfer", rd, {24'h0, c[1:0], hit ? b : 6'h00});
        end
    end
    apb(1'h1, OFS_MODE_BASE + 8'h0C, MD_COMP_MIN);
    apb(1'h1, OFS_DEAD, 32'h2);
    for (int p = 0; p < 2; p++)
    begin
      apb(1'h1, OFS_OCR2, p << 5);
      e = '0;
      e.count_start = 1'h1;
      pulse(e);
      check("initial level", pins.ch4_pin_d, !p[0]);
      e = '0;
      e.ch4_cmp_d = 1'h1;
      @(posedge clk);
      down <= 1'h1;
      pulse(e);
      check("held in dead time", pins.ch4_pin_d, !p[0]);
      settle(8);
      pulse(e);
      check("down count level", pins.ch4_pin_d, p[0]);
      @(posedge clk);
      down <= 1'h0;
      pulse(e);
      check("up count level", pins.ch4_pin_d, !p[0]);
    end
    apb(1'h1, OFS_OCR1, 32'h40);
    n = flips;
    e = '0;
    e.ch4_crest = 1'h1;
    repeat (3) pulse(e);
    settle(2);
    check("toggle count", flips - n, 3);
    apb(1'h1, OFS_OCR1, 32'h0);
    settle(2);
    check("toggle off", pins.sync_toggle, 1'h0);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'h1, OFS_MODE_BASE, i[0] ? 32'h40 : 32'h0);
      e = '0;
      e.ch0_match = 6'($random(seed));
      e.ch0_ovf = 1'($random(seed));
      e.ch5_match = 3'($random(seed));
      pulse(e);
      check("ch0 sources", irq0, {e.ch0_ovf, e.ch0_match});
      check("ch5 sources", irq5, e.ch5_match);
      check("ef buffer", efx, i[0] & e.ch0_match[4]);
      settle(1);
      check("ch0 pulse width", irq0, 7'h00);
    end
    wrap_up();
  end
endmodule
